// File: logic/ubb_top.sv
/*
  Baud divider, break field control and input source switching for one
  asynchronous serial unit, with an AXI4-Lite register slave.
  Assumes the base clock selector supplies a tick in this clock domain and
  that the ordinary transmitter and receiver sit outside this block.
*/
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module ubb_top (
  input  wire logic                  I_SYS_CLK,            // 200 MHz system clock.
  input  wire logic                  I_RESET_N,            // Asynchronous reset, active low.
  input  wire ubb_pkg::ubb_axi_req_t I_AXI,                // Bus master signals.
  output ubb_pkg::ubb_axi_rsp_t      O_AXI,                // Bus slave signals.
  input  wire logic                  I_BASE_TICK,          // Base clock tick, same domain.
  input  wire logic                  I_TX_DATA,            // Ordinary transmitter bit level.
  input  wire logic                  I_SERIAL_RX_LINE,     // Receive pin.
  input  wire logic                  I_EXT_IRQ_PIN,        // External interrupt pin.
  input  wire logic                  I_CAPTURE_PIN,        // Timer capture pin.
  output logic                       O_SERIAL_TX_LINE,     // Transmit pin level.
  output logic                       O_TX_PIN_OWNED,       // Transmit pin taken by the unit.
  output logic                       O_RX_LINE,            // Receive level for the receiver.
  output logic                       O_EXTERNAL_IRQ_INPUT, // Routed interrupt input.
  output logic                       O_TIMER_CAPTURE_INPUT,// Routed capture input.
  output logic                       O_BIT_TICK,           // One pulse per bit time.
  output logic [7:0]                 O_SERIAL_MODE,        // Serial mode register.
  output logic                       O_BIT_ORDER_LSB,      // Bit order for the shifters.
  output logic                       O_TX_DONE_IRQ,        // Break transmit done pulse.
  output logic                       O_RX_DONE_IRQ         // Break receive done pulse.
);
  import ubb_pkg::*;

  // Register file state, on the main reset.
  logic [7:0] isw_reg, isw_next;       // Input source switch.
  logic [7:0] mode_reg, mode_next;     // Serial mode register.
  logic [7:0] div_reg, div_next;       // Divide value.
  logic [4:0] ctl_reg, ctl_next;       // Length, order and inversion fields.

  // Bus slave state.
  logic        aw_got_reg, aw_got_next;  // Write address held.
  logic        w_got_reg, w_got_next;    // Write data held.
  logic [19:0] waddr_reg, waddr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        wstrb_reg, wstrb_next;    // Lane zero strobe.
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;

  // Break state, on the unit reset.
  ubb_brx_t   brx_reg, brx_next;
  logic       rx_trig_reg, rx_trig_next;    // Receive trigger in force.
  logic       rx_stat_reg, rx_stat_next;    // Break receive status.
  logic [4:0] rx_cnt_reg, rx_cnt_next;      // Low bit times seen.
  ubb_btx_t   btx_reg, btx_next;
  logic [4:0] tx_cnt_reg, tx_cnt_next;      // Low bit times sent.
  logic       txi_reg, txi_next;
  logic       rxi_reg, rxi_next;

  // Pin synchronisers and routed outputs.
  logic [2:0] sync1_reg, sync2_reg;  // Stage one is read only by stage two.
  logic       irq_out_reg, cap_out_reg, tx_out_reg, own_reg;
  logic       irq_out_next, cap_out_next, tx_out_next, own_next;

  logic       core_rst_n;   // Unit reset: main reset or power off.
  logic       bit_tick;
  logic       wr_do;        // Write performed this cycle.
  logic [3:0] wsel, rsel;
  logic       power, txe, rxe, rx_sync;

  assign power   = mode_reg[MODE_POWER_BIT];
  assign txe     = mode_reg[MODE_TXE_BIT];
  assign rxe     = mode_reg[MODE_RXE_BIT];
  assign rx_sync = sync2_reg[0];
  assign wsel    = ubb_decode(waddr_reg);
  assign rsel    = ubb_decode(I_AXI.araddr);
  assign wr_do   = aw_got_reg & w_got_reg & ~bvalid_reg;

  // Power off resets the unit at once; the term comes from a flop, so it is glitch free.
  assign core_rst_n = I_RESET_N & power;

  ubb_baud_gen #(.W(8)) u_baud (
    .i_clk      (I_SYS_CLK),
    .i_rst_n    (core_rst_n),
    .i_base_tick(I_BASE_TICK),
    .i_divide   (div_reg),
    .o_bit_tick (bit_tick)
  );

  // Bus slave: address and data are taken in either order, the response follows both.
  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (I_AXI.awvalid && !aw_got_reg) begin
      aw_got_next = 1'b1;
      waddr_next  = I_AXI.awaddr;
    end
    if (I_AXI.wvalid && !w_got_reg) begin
      w_got_next = 1'b1;
      wdata_next = I_AXI.wdata[7:0];
      wstrb_next = I_AXI.wstrb[0];
    end
    if (bvalid_reg && I_AXI.bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_do) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rvalid_reg && I_AXI.rready) begin
      rvalid_next = 1'b0;
    end
    // A read is taken only while no answer is pending.
    if (I_AXI.arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      if (rsel == SEL_ISW) begin
        rdata_next = isw_reg & ISW_MASK;
      end else if (rsel == SEL_MODE) begin
        rdata_next = mode_reg;
      end else if (rsel == SEL_DIV) begin
        rdata_next = div_reg;
      end else if (rsel == SEL_CTL) begin
        // Both triggers read as zero.
        rdata_next = {rx_stat_reg, 2'h0, ctl_reg};
      end else begin
        rdata_next = 8'h00;
        rresp_next = RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      waddr_reg  <= 20'h00000;
      wdata_reg  <= 8'h00;
      wstrb_reg  <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= RESP_OKAY;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      waddr_reg  <= waddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  // Plain register fields; a write of the same value changes nothing downstream.
  always_comb begin
    isw_next  = isw_reg;
    mode_next = mode_reg;
    div_next  = div_reg;
    ctl_next  = ctl_reg;
    if (wr_do && wstrb_reg) begin
      if (wsel == SEL_ISW) begin
        isw_next = wdata_reg & ISW_MASK;
      end else if (wsel == SEL_MODE) begin
        mode_next = wdata_reg;
      end else if (wsel == SEL_DIV) begin
        div_next = wdata_reg;
      end else if (wsel == SEL_CTL) begin
        ctl_next = wdata_reg[CTL_LEN_HI:CTL_INVERT_BIT];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      isw_reg  <= RST_INPUT_SWITCH;
      mode_reg <= RST_SERIAL_MODE;
      div_reg  <= RST_BAUD_DIVIDER;
      ctl_reg  <= RST_LINK_CONTROL[CTL_LEN_HI:CTL_INVERT_BIT];
    end else begin
      isw_reg  <= isw_next;
      mode_reg <= mode_next;
      div_reg  <= div_next;
      ctl_reg  <= ctl_next;
    end
  end

  // Break sequencing. Triggers act only on a written one, so a refresh with zeros is harmless.
  always_comb begin
    brx_next     = brx_reg;
    rx_trig_next = rx_trig_reg;
    rx_stat_next = rx_stat_reg;
    rx_cnt_next  = rx_cnt_reg;
    btx_next     = btx_reg;
    tx_cnt_next  = tx_cnt_reg;
    txi_next     = 1'b0;
    rxi_next     = 1'b0;
    case (brx_reg)
      BRX_WAIT: begin
        if (!rx_sync) begin
          brx_next    = BRX_MEASURE;
          rx_cnt_next = 5'h00;
        end
      end
      BRX_MEASURE: begin
        if (rx_sync) begin
          if (rx_cnt_reg >= BRK_RX_MIN_BITS) begin
            brx_next     = BRX_OFF;
            rx_trig_next = 1'b0;
            rx_stat_next = 1'b0;
            rxi_next     = 1'b1;
          end else begin
            brx_next = BRX_WAIT;
          end
        end else if (bit_tick && rx_cnt_reg != 5'h1F) begin
          rx_cnt_next = rx_cnt_reg + 5'h01;
        end
      end
      default: begin
      end
    endcase
    case (btx_reg)
      BTX_LOW: begin
        if (bit_tick) begin
          tx_cnt_next = tx_cnt_reg + 5'h01;
          if (tx_cnt_reg + 5'h01 >= ubb_break_len(ctl_reg[CTL_LEN_HI:CTL_LEN_LO])) begin
            btx_next = BTX_IDLE;
            txi_next = 1'b1;
          end
        end
      end
      default: begin
      end
    endcase
    if (wr_do && wstrb_reg && wsel == SEL_CTL) begin
      if (wdata_reg[CTL_RX_TRIG_BIT] && rxe) begin
        brx_next     = BRX_WAIT;
        rx_trig_next = 1'b1;
        rx_stat_next = 1'b1;
      end
      if (wdata_reg[CTL_TX_TRIG_BIT] && txe && btx_reg == BTX_IDLE) begin
        btx_next    = BTX_LOW;
        tx_cnt_next = 5'h00;
      end
    end
    // Disabling a direction resets its side of the break logic.
    if (!rxe) begin
      brx_next     = BRX_OFF;
      rx_trig_next = 1'b0;
      rx_stat_next = 1'b0;
    end
    if (!txe) begin
      btx_next = BTX_IDLE;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      brx_reg     <= BRX_OFF;
      rx_trig_reg <= 1'b0;
      rx_stat_reg <= 1'b0;
      rx_cnt_reg  <= 5'h00;
      btx_reg     <= BTX_IDLE;
      tx_cnt_reg  <= 5'h00;
      txi_reg     <= 1'b0;
      rxi_reg     <= 1'b0;
    end else begin
      brx_reg     <= brx_next;
      rx_trig_reg <= rx_trig_next;
      rx_stat_reg <= rx_stat_next;
      rx_cnt_reg  <= rx_cnt_next;
      btx_reg     <= btx_next;
      tx_cnt_reg  <= tx_cnt_next;
      txi_reg     <= txi_next;
      rxi_reg     <= rxi_next;
    end
  end

  // Pin levels and routing. With power off the line idles high before inversion.
  always_comb begin
    irq_out_next = isw_reg[ISW_IRQ_BIT] ? rx_sync : sync2_reg[1];
    cap_out_next = isw_reg[ISW_CAP_BIT] ? rx_sync : sync2_reg[2];
    if (!power) begin
      tx_out_next = 1'b1 ^ ctl_reg[CTL_INVERT_BIT];
    end else if (btx_reg == BTX_LOW) begin
      tx_out_next = 1'b0 ^ ctl_reg[CTL_INVERT_BIT];
    end else begin
      tx_out_next = I_TX_DATA ^ ctl_reg[CTL_INVERT_BIT];
    end
    own_next = ctl_reg[CTL_INVERT_BIT] | (power & txe);
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      sync1_reg   <= 3'h7;
      sync2_reg   <= 3'h7;
      irq_out_reg <= 1'b1;
      cap_out_reg <= 1'b1;
      tx_out_reg  <= 1'b1;
      own_reg     <= 1'b0;
    end else begin
      sync1_reg   <= {I_CAPTURE_PIN, I_EXT_IRQ_PIN, I_SERIAL_RX_LINE};
      sync2_reg   <= sync1_reg;
      irq_out_reg <= irq_out_next;
      cap_out_reg <= cap_out_next;
      tx_out_reg  <= tx_out_next;
      own_reg     <= own_next;
    end
  end

  // Outputs.
  assign O_AXI.awready         = ~aw_got_reg;
  assign O_AXI.wready          = ~w_got_reg;
  assign O_AXI.bvalid          = bvalid_reg;
  assign O_AXI.bresp           = bresp_reg;
  assign O_AXI.arready         = ~rvalid_reg;
  assign O_AXI.rvalid          = rvalid_reg;
  assign O_AXI.rdata           = {24'h000000, rdata_reg};
  assign O_AXI.rresp           = rresp_reg;
  assign O_SERIAL_TX_LINE      = tx_out_reg;
  assign O_TX_PIN_OWNED        = own_reg;
  assign O_RX_LINE             = power ? rx_sync : 1'b1;
  assign O_EXTERNAL_IRQ_INPUT  = irq_out_reg;
  assign O_TIMER_CAPTURE_INPUT = cap_out_reg;
  assign O_BIT_TICK            = bit_tick;
  assign O_SERIAL_MODE         = mode_reg;
  assign O_BIT_ORDER_LSB       = ctl_reg[CTL_ORDER_BIT];
  assign O_TX_DONE_IRQ         = txi_reg;
  assign O_RX_DONE_IRQ         = rxi_reg;

  // Helper: base ticks since the last bit tick, and the divide value caught at that tick.
  logic [9:0] span_reg;
  logic [7:0] span_div_reg;  // A period that saw a divider change is left unchecked.
  always_ff @(posedge I_SYS_CLK or negedge core_rst_n) begin
    if (!core_rst_n) begin
      span_reg     <= 10'h000;
      span_div_reg <= 8'h00;
    end else begin
      span_reg     <= bit_tick ? 10'(I_BASE_TICK) : span_reg + 10'(I_BASE_TICK);
      span_div_reg <= bit_tick ? div_reg : span_div_reg;
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESET_N);

  a_div_reset: assert property ($rose(I_RESET_N) |-> div_reg == 8'hFF) else $error("divider reset wrong");
  a_ctl_reset: assert property ($rose(I_RESET_N) |-> {2'h0, ctl_reg} == 7'h16) else $error("control reset wrong");
  a_isw_upper: assert property (isw_reg[7:2] == 6'h00) else $error("switch upper bits set");
  a_bit_span: assert property (bit_tick && span_div_reg == div_reg && div_reg >= 8'h04 && span_reg != 10'h000
    |-> span_reg == {1'b0, div_reg, 1'b0}) else $error("bit period not 2k");
  a_trig_read: assert property (I_AXI.arvalid && !rvalid_reg && rsel == SEL_CTL |=> rdata_reg[6:5] == 2'h0)
    else $error("trigger read nonzero");
  a_brk_low: assert property (power && btx_reg == BTX_LOW |=> tx_out_reg == ctl_reg[0] || !power)
    else $error("break not low");
  a_brk_len: assert property (txi_reg |-> tx_cnt_reg == ubb_break_len(ctl_reg[4:2])) else $error("break length wrong");
  a_rx_err_hold: assert property (brx_reg == BRX_MEASURE && rx_sync && rx_cnt_reg < 5'h0B && rxe && power
    |=> brx_reg == BRX_WAIT && rx_stat_reg) else $error("bad break not held");
  a_rx_done: assert property (rxi_reg |-> !rx_stat_reg && !rx_trig_reg) else $error("done without clear");
  a_power_off: assert property (!power |-> !rx_stat_reg && !rx_trig_reg) else $error("power off not reset");
  a_pin_owned: assert property (ctl_reg[0] |=> own_reg) else $error("inverted pin released");
  a_irq_route: assert property (isw_reg[ISW_IRQ_BIT] |=> irq_out_reg == $past(rx_sync))
    else $error("irq routing wrong");

endmodule

// File: logic/ubb_pkg.sv
/*
  Package for the baud divider and break control block: register indices and
  byte addresses, field positions, reset values, bus carriers and helpers.
  Assumes a 32-bit AXI4-Lite master and a 200 MHz system clock.
*/
// Contract
// - Divide base clock by k, 4 to 255.
// - Bit rate is counter output over two.
// - Divider resets to all ones, 255.
// - Identical rewrites never disturb communication.
// - Control register resets to 0x16.
// - Break status reads 1 while receiving break.
// - Bad break returns to waiting, status held.
// - Receive trigger reads 0, self-clears on success.
// - Transmit trigger reads 0, self-clears at end.
// - Length code selects 13 to 20 bits.
// - Bit order 0 MSB, 1 LSB first.
// - Inversion flips line and keeps pin owned.
// - Switch bits route receive line to inputs.
// - Switch register resets zero, upper bits zero.
// - Power off resets break status and trigger.
package ubb_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [15:0] IDX_INPUT_SWITCH = 16'hFF4F;
  localparam logic [15:0] IDX_SERIAL_MODE  = 16'hFF50;
  localparam logic [15:0] IDX_BAUD_DIVIDER = 16'hFF57;
  localparam logic [15:0] IDX_LINK_CONTROL = 16'hFF58;
  localparam int          ADDR_W           = 20;
  localparam logic [19:0] ADDR_INPUT_SWITCH = {2'h0, IDX_INPUT_SWITCH, 2'h0};
  localparam logic [19:0] ADDR_SERIAL_MODE  = {2'h0, IDX_SERIAL_MODE, 2'h0};
  localparam logic [19:0] ADDR_BAUD_DIVIDER = {2'h0, IDX_BAUD_DIVIDER, 2'h0};
  localparam logic [19:0] ADDR_LINK_CONTROL = {2'h0, IDX_LINK_CONTROL, 2'h0};

  // Reset values.
  localparam logic [7:0] RST_INPUT_SWITCH = 8'h00;
  localparam logic [7:0] RST_SERIAL_MODE  = 8'h01;
  localparam logic [7:0] RST_BAUD_DIVIDER = 8'hFF;
  localparam logic [7:0] RST_LINK_CONTROL = 8'h16;

  // Serial mode register fields.
  localparam int MODE_POWER_BIT = 7;
  localparam int MODE_TXE_BIT   = 6;
  localparam int MODE_RXE_BIT   = 5;

  // Link control register fields.
  localparam int CTL_RX_STATUS_BIT = 7;
  localparam int CTL_RX_TRIG_BIT   = 6;
  localparam int CTL_TX_TRIG_BIT   = 5;
  localparam int CTL_LEN_HI        = 4;
  localparam int CTL_LEN_LO        = 2;
  localparam int CTL_ORDER_BIT     = 1;
  localparam int CTL_INVERT_BIT    = 0;

  // Input switch fields; bits above are fixed zero.
  localparam int ISW_IRQ_BIT = 0;
  localparam int ISW_CAP_BIT = 1;
  localparam logic [7:0] ISW_MASK = 8'h03;

  // Divider limits and break figures.
  localparam logic [7:0] DIV_MIN          = 8'h04;
  localparam logic [4:0] BRK_RX_MIN_BITS  = 5'h0B;
  localparam logic [4:0] BRK_LEN_BASE_LO  = 5'h10;
  localparam logic [4:0] BRK_LEN_BASE_HI  = 5'h08;
  localparam logic [2:0] BRK_LEN_WRAP     = 3'h5;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector, one-hot.
  localparam logic [3:0] SEL_NONE = 4'h0;
  localparam logic [3:0] SEL_ISW  = 4'h1;
  localparam logic [3:0] SEL_MODE = 4'h2;
  localparam logic [3:0] SEL_DIV  = 4'h4;
  localparam logic [3:0] SEL_CTL  = 4'h8;

  // Master-to-slave bus signals.
  typedef struct packed {
    logic [19:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [19:0] araddr;
    logic        arvalid;
    logic        rready;
  } ubb_axi_req_t;

  // Slave-to-master bus signals.
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ubb_axi_rsp_t;

  typedef enum logic [1:0] {BRX_OFF, BRX_WAIT, BRX_MEASURE} ubb_brx_t;
  typedef enum logic [0:0] {BTX_IDLE, BTX_LOW} ubb_btx_t;

  // Address decode shared by the read and write paths.
  function automatic logic [3:0] ubb_decode(input logic [19:0] addr);
    logic [3:0] sel;
    sel = SEL_NONE;
    if (addr == ADDR_INPUT_SWITCH) begin
      sel = SEL_ISW;
    end else if (addr == ADDR_SERIAL_MODE) begin
      sel = SEL_MODE;
    end else if (addr == ADDR_BAUD_DIVIDER) begin
      sel = SEL_DIV;
    end else if (addr == ADDR_LINK_CONTROL) begin
      sel = SEL_CTL;
    end
    return sel;
  endfunction

  // Break length in bits: codes 5..7 give 13..15, codes 0..4 give 16..20.
  function automatic logic [4:0] ubb_break_len(input logic [2:0] code);
    logic [4:0] len;
    len = (code >= BRK_LEN_WRAP) ? (BRK_LEN_BASE_HI + {2'h0, code}) : (BRK_LEN_BASE_LO + {2'h0, code});
    return len;
  endfunction

endpackage

// File: logic/ubb_baud_gen.sv
/*
  Bit-rate generator: an 8-bit counter divides the base clock ticks by k, and
  the counter output is halved once more to give one tick per bit time.
  Assumes i_base_tick is a one-cycle pulse from the base clock selector in
  the same clock domain, and that its reset is held while the unit is off.
*/
`timescale 1ns/1ps
module ubb_baud_gen #(
  parameter int W = 8
) (
  input  wire logic         i_clk,        // System clock.
  input  wire logic         i_rst_n,      // Unit reset, active low.
  input  wire logic         i_base_tick,  // One pulse per base clock period.
  input  wire logic [W-1:0] i_divide,     // Divide value k.
  output logic              o_bit_tick    // One pulse per bit time.
);
  import ubb_pkg::*;

  logic [W-1:0] cnt_reg;     // Base ticks counted within one counter period.
  logic [W-1:0] cnt_next;
  logic         phase_reg;   // Counter output clock level.
  logic         phase_next;
  logic         tick_reg;    // Registered bit tick.
  logic         tick_next;
  logic [W-1:0] k_eff;       // Divide value after clamping.

  // Prohibited values below four run as four so the counter never stalls.
  assign k_eff = (i_divide < W'(DIV_MIN)) ? W'(DIV_MIN) : i_divide;

  // Counter wraps every k base ticks; every second wrap is one bit time.
  always_comb begin
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    tick_next  = 1'b0;
    if (i_base_tick) begin
      if (cnt_reg >= k_eff - W'(1)) begin
        cnt_next   = '0;
        phase_next = ~phase_reg;
        tick_next  = phase_reg;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  // State registers only.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      tick_reg  <= tick_next;
    end
  end

  assign o_bit_tick = tick_reg;

endmodule

// File: dv/ubb_peer.sv
/*
  Remote serial node: sends a low break of a chosen bit count on the line.
  Assumes the bit ticks of the block pace its bits.
*/
`timescale 1ns/1ps
module ubb_peer (
  input  wire logic       i_clk,  // System clock.
  input  wire logic       i_tick, // One pulse per bit time.
  input  wire logic       i_go,   // Starts a break.
  input  wire logic [4:0] i_len,  // Break length in bits.
  output logic            o_rx    // Line towards the block.
);
  logic [4:0] cnt_reg = 5'h00; // Bits still to hold low.
  // The line has a pull-up, so it reads high outside a break.
  always_ff @(posedge i_clk) begin
    if (i_go) begin
      cnt_reg <= i_len;
    end else if (i_tick && cnt_reg != 5'h00) begin
      cnt_reg <= cnt_reg - 5'h01;
    end
  end
  assign o_rx = (cnt_reg == 5'h00);
endmodule

// File: dv/testbench.sv
/*
  Self-checking bench for ubb_top with a peer node on the receive line.
  Assumes the register slave timing given with the design.
*/
`timescale 1ns/1ps
module testbench;
  import ubb_pkg::*;
  logic         clk = 1'b0, rst_n = 1'b0, go = 1'b0, irqp = 1'b0, capp = 1'b0;
  logic         rxl, tx, own, eirq, tcap, tick, lsb, txd, rxd;
  logic         bt = 1'b0, tdat = 1'b1, rxo;
  localparam int BP = 2; // Base tick period in clock cycles.
  logic [4:0]   blen = 5'h00;
  logic [7:0]   r, mode;
  logic [1:0]   rs;
  logic [31:0]  seed = 32'h0000003F;
  ubb_axi_req_t q = '0;
  ubb_axi_rsp_t s;
  int           err_count = 0, cmp_count = 0, cyc = 0, n, lo, k, c;
  always #2.5 clk = ~clk;
  // Base tick on every other cycle, so the divider has to gate on it.
  always @(posedge clk) bt <= ~bt;
  ubb_top u_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_AXI(q), .O_AXI(s), .I_BASE_TICK(bt),
    .I_TX_DATA(tdat), .I_SERIAL_RX_LINE(rxl), .I_EXT_IRQ_PIN(irqp), .I_CAPTURE_PIN(capp),
    .O_SERIAL_TX_LINE(tx), .O_TX_PIN_OWNED(own), .O_RX_LINE(rxo), .O_EXTERNAL_IRQ_INPUT(eirq),
    .O_TIMER_CAPTURE_INPUT(tcap), .O_BIT_TICK(tick), .O_SERIAL_MODE(mode), .O_BIT_ORDER_LSB(lsb),
    .O_TX_DONE_IRQ(txd), .O_RX_DONE_IRQ(rxd));
  ubb_peer u_peer (.i_clk(clk), .i_tick(tick), .i_go(go), .i_len(blen), .o_rx(rxl));
  // Xorshift source; the fixed start keeps runs repeatable.
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Break length in bits for a length code.
  function automatic int bl(input int x);
    return (x >= 5) ? x + 8 : x + 16;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge clk);
    {pa, pw} = 2'h3;
    q.awaddr <= a;
    q.wdata <= {24'h000000, d};
    q.wstrb <= 4'hF;
    q.awvalid <= 1'b1;
    q.wvalid <= 1'b1;
    q.bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (s.awready) q.awvalid <= 1'b0;
      if (s.wready) q.wvalid <= 1'b0;
      pa = pa && !s.awready;
      pw = pw && !s.wready;
    end
    while (s.bvalid !== 1'b1) @(posedge clk);
    q.bready <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a);
    @(posedge clk);
    q.araddr <= a;
    q.arvalid <= 1'b1;
    q.rready <= 1'b1;
    do @(posedge clk); while (s.arready !== 1'b1);
    q.arvalid <= 1'b0;
    do @(posedge clk); while (s.rvalid !== 1'b1);
    {rs, r} = {s.rresp, s.rdata[7:0]};
    q.rready <= 1'b0;
  endtask
  task automatic rc(input logic [19:0] a, input logic [7:0] e);
    rd(a);
    chk({rs, r}, {RESP_OKAY, e});
  endtask
  // Waits up to m cycles for a one-cycle flag.
  task automatic wt(ref logic f, input int m);
    n = 0;
    lo = 0;
    do begin
      @(posedge clk);
      n++;
      lo += (tx === 1'b0);
    end while (f !== 1'b1 && n < m);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rc(ADDR_INPUT_SWITCH, 8'h00);
    rc(ADDR_BAUD_DIVIDER, 8'hFF);
    rc(ADDR_LINK_CONTROL, 8'h16);
    rd(20'h00010);
    chk(rs, RESP_SLVERR);
    $display("reset test done");
    for (c = 0; c < 8; c++) begin
      seed = xs(seed);
      irqp <= seed[8];
      capp <= seed[9];
      wr(ADDR_INPUT_SWITCH, seed[7:0]);
      rc(ADDR_INPUT_SWITCH, {6'h00, seed[1:0]});
      chk(eirq, seed[0] ? rxl : seed[8]);
      chk(tcap, seed[1] ? rxl : seed[9]);
    end
    $display("routing test done");
    for (k = 4; k < 6; k++) begin
      tdat <= k[0];
      wr(ADDR_SERIAL_MODE, 8'h80);
      wr(ADDR_BAUD_DIVIDER, k[7:0]);
      wr(ADDR_SERIAL_MODE, 8'hE0);
      wr(ADDR_BAUD_DIVIDER, k[7:0]);
      wt(tick, 2000);
      wt(tick, 2000);
      chk(n, 2 * k * BP);
      chk(tx, k[0]);
    end
    $display("divider test done");
    k = 5;
    for (c = 0; c < 8; c++) begin
      wr(ADDR_LINK_CONTROL, {3'h1, c[2:0], 2'h2});
      wt(txd, 1000);
      chk(lo > (bl(c) - 1) * 2 * k * BP && lo <= bl(c) * 2 * k * BP + 2, 1);
      rc(ADDR_LINK_CONTROL, {3'h0, c[2:0], 2'h2});
      chk(tx, 1'b1);
    end
    $display("break send test done");
    wr(ADDR_SERIAL_MODE, 8'h00);
    wr(ADDR_LINK_CONTROL, 8'h15);
    @(posedge clk);
    chk({own, lsb, tx}, 3'h4);
    wr(ADDR_LINK_CONTROL, 8'h16);
    @(posedge clk);
    chk({own, lsb, tx}, 3'h3);
    wr(ADDR_SERIAL_MODE, 8'hA0);
    wr(ADDR_LINK_CONTROL, 8'h56);
    rc(ADDR_LINK_CONTROL, 8'h96);
    blen <= 5'h05;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    chk(rxo, 1'b0);
    repeat (200) @(posedge clk);
    rc(ADDR_LINK_CONTROL, 8'h96);
    blen <= 5'h0D;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wt(rxd, 600);
    chk(rxd, 1'b1);
    rc(ADDR_LINK_CONTROL, 8'h16);
    wr(ADDR_LINK_CONTROL, 8'h56);
    wr(ADDR_SERIAL_MODE, 8'h00);
    rc(ADDR_LINK_CONTROL, 8'h16);
    chk({mode, rxo}, 9'h001);
    $display("break receive test done");
    end_of_test();
  end
endmodule
